// >>> design/flash_regs_pkg.sv
// Constants for the flash configuration and protection register set.
// Assumes a 32-bit Avalon-MM slave on byte addresses, one register per aligned word.
package flash_regs_pkg;
   localparam int BANKS = 4;
   // Register byte offsets.
   localparam logic [11:0] CLOCK_DIVIDER_OFS = 12'h100;
   localparam logic [11:0] SECTOR_PROTECTION_OFS = 12'h104;
   localparam logic [11:0] STATUS_REGISTER_OFS = 12'h108;
   localparam logic [11:0] SECURITY_STATE_OFS = 12'h10c;
   localparam logic [11:0] TEST_MODE_CONTROL_OFS = 12'h110;
   localparam logic [11:0] MODULE_CONFIGURATION_OFS = 12'h114;
   // Clock divider fields.
   localparam int DIVIDER_LOADED_BIT = 7;
   localparam int PRESCALE_ENABLE_BIT = 6;
   localparam logic [7:0] CLOCK_DIVIDER_RST = 8'h00;
   localparam logic [2:0] PRESCALE_LAST = 3'h7;
   // Security fields.
   localparam logic [1:0] KEY_ENABLED = 2'h2;
   localparam logic [1:0] UNSECURED = 2'h2;
   // Test mode control fields.
   localparam int WRITE_ALL_BANKS_BIT = 4;
   // Module configuration fields.
   localparam int BUFFER_EMPTY_IRQ_ENABLE_BIT = 7;
   localparam int COMPLETE_IRQ_ENABLE_BIT = 6;
   localparam int KEY_WRITE_GATE_BIT = 5;
   localparam logic [7:0] MODULE_CONFIGURATION_MASK = 8'he3;
   localparam logic [7:0] MODULE_CONFIGURATION_RST = 8'h00;
   // Sector protection fields.
   localparam int PROTECTION_OPEN_BIT = 7;
   localparam int RESERVED_FLAG_BIT = 6;
   localparam int HIGH_RANGE_DISABLE_BIT = 5;
   localparam int LOW_RANGE_DISABLE_BIT = 2;
   localparam logic [7:0] SECTOR_PROTECTION_RST = 8'hff;
   // Status fields.
   localparam int BUFFER_EMPTY_FLAG_BIT = 7;
   localparam int COMMAND_COMPLETE_FLAG_BIT = 6;
   localparam int PROTECTION_VIOLATION_BIT = 5;
   // Protected range geometry inside a block.
   localparam logic [16:0] BLOCK_END = 17'h10000;
   localparam logic [16:0] HIGH_RANGE_MIN = 17'h00800;
   localparam logic [15:0] LOW_RANGE_BASE = 16'h4000;
   localparam logic [15:0] LOW_RANGE_MIN = 16'h0200;
   typedef enum logic {ST_LOAD, ST_RUN} load_state_t;
endpackage

// >>> design/flash_config_protect_regs.sv
// Flash module control, configuration, security and per-block protection registers.
// Assumes an Avalon-MM master on ref_clk_i and nonvolatile option bytes valid at reset release.
`timescale 1ns/10ps
`default_nettype none
module flash_config_protect_regs (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [11:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic special_mode_i,
   input wire logic [7:0] nv_security_i,
   input wire logic [31:0] nv_protection_i,
   input wire logic unlock_ok_i,
   input wire logic [3:0] buffer_empty_i,
   input wire logic [3:0] command_complete_i,
   input wire logic array_write_i,
   input wire logic [1:0] array_bank_i,
   input wire logic [15:0] array_addr_i,
   input wire logic mass_erase_i,
   output logic launch_o,
   output logic key_word_o,
   output logic key_write_gate_o,
   output logic fclk_tick_o,
   output logic irq_o,
   output logic backdoor_enabled_o,
   output logic secured_o
);
   flash_regs_pkg::load_state_t state_ff;
   logic [7:0] divider_ff;
   logic [7:0] security_ff;
   logic [7:0] config_ff;
   logic wr_all_ff;
   logic [7:0] prot_ff [flash_regs_pkg::BANKS];
   logic [3:0] viol_ff;
   logic [2:0] mode_sync_ff;
   logic special_ff;
   logic waitrequest_ff;
   logic [31:0] readdata_ff;
   logic [2:0] pre_cnt_ff;
   logic [5:0] div_cnt_ff;
   logic fclk_tick_ff;
   logic irq_ff;
   logic launch_ff;
   logic key_word_ff;
   logic backdoor_ff;
   logic secured_ff;
   logic wr_fire;
   logic [7:0] wd;
   logic [7:0] rd_byte;
   logic [1:0] bank;
   logic key_ok;
   logic pre_tick;
   logic hit_viol;

   assign bank = config_ff[1:0];
   assign wd = writedata_i[7:0];
   assign wr_fire = write_i && !waitrequest_ff && byteenable_i[0];
   assign key_ok = (security_ff[7:6] == flash_regs_pkg::KEY_ENABLED);

   function automatic logic prot_hit(input logic [7:0] p, input logic [15:0] a,
                                     input logic mass);
      logic [16:0] hsize;
      logic [15:0] lsize;
      logic in_hi;
      logic in_lo;
      hsize = flash_regs_pkg::HIGH_RANGE_MIN << p[4:3];
      lsize = flash_regs_pkg::LOW_RANGE_MIN << p[1:0];
      in_hi = ({1'b0, a} >= (flash_regs_pkg::BLOCK_END - hsize));
      in_lo = (a >= flash_regs_pkg::LOW_RANGE_BASE) &&
              (a < (flash_regs_pkg::LOW_RANGE_BASE + lsize));
      if (mass) begin
         prot_hit = !(p[flash_regs_pkg::PROTECTION_OPEN_BIT] &&
                      p[flash_regs_pkg::HIGH_RANGE_DISABLE_BIT] &&
                      p[flash_regs_pkg::LOW_RANGE_DISABLE_BIT]);
      end else begin
         prot_hit = !p[flash_regs_pkg::PROTECTION_OPEN_BIT] ||
                    (!p[flash_regs_pkg::HIGH_RANGE_DISABLE_BIT] && in_hi) ||
                    (!p[flash_regs_pkg::LOW_RANGE_DISABLE_BIT] && in_lo);
      end
   endfunction

   assign hit_viol = array_write_i && !config_ff[flash_regs_pkg::KEY_WRITE_GATE_BIT] &&
                     prot_hit(prot_ff[array_bank_i], array_addr_i, mass_erase_i);

   // Reset sequence: one cycle to capture the option bytes, then normal running.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= flash_regs_pkg::ST_LOAD;
      end else begin
         state_ff <= flash_regs_pkg::ST_RUN;
      end
   end

   // Special mode pin passes three flops; a change counts once the last two agree.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_sync_ff <= 3'h0;
         special_ff <= 1'b0;
      end else begin
         mode_sync_ff <= {mode_sync_ff[1:0], special_mode_i};
         if (mode_sync_ff[1] == mode_sync_ff[2]) begin
            special_ff <= mode_sync_ff[2];
         end
      end
   end

   // Bus handshake: one wait cycle, then waitrequest low for one cycle.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         waitrequest_ff <= 1'b1;
         readdata_ff <= 32'h0000_0000;
      end else begin
         if ((read_i || write_i) && waitrequest_ff &&
             state_ff == flash_regs_pkg::ST_RUN) begin
            waitrequest_ff <= 1'b0;
            readdata_ff <= {24'h00_0000, read_i ? rd_byte : 8'h00};
         end else begin
            waitrequest_ff <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      case (address_i)
         flash_regs_pkg::CLOCK_DIVIDER_OFS: rd_byte = divider_ff;
         flash_regs_pkg::SECURITY_STATE_OFS: rd_byte = security_ff;
         flash_regs_pkg::TEST_MODE_CONTROL_OFS: begin
            rd_byte[flash_regs_pkg::WRITE_ALL_BANKS_BIT] = wr_all_ff && special_ff;
         end
         flash_regs_pkg::MODULE_CONFIGURATION_OFS: begin
            rd_byte = config_ff & flash_regs_pkg::MODULE_CONFIGURATION_MASK;
         end
         flash_regs_pkg::SECTOR_PROTECTION_OFS: rd_byte = prot_ff[bank];
         flash_regs_pkg::STATUS_REGISTER_OFS: begin
            rd_byte[flash_regs_pkg::BUFFER_EMPTY_FLAG_BIT] = buffer_empty_i[bank];
            rd_byte[flash_regs_pkg::COMMAND_COMPLETE_FLAG_BIT] = command_complete_i[bank];
            rd_byte[flash_regs_pkg::PROTECTION_VIOLATION_BIT] = viol_ff[bank];
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // Clock divider: write once for bits 6-0, loaded flag set by that write.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         divider_ff <= flash_regs_pkg::CLOCK_DIVIDER_RST;
      end else if (wr_fire && address_i == flash_regs_pkg::CLOCK_DIVIDER_OFS &&
                   !divider_ff[flash_regs_pkg::DIVIDER_LOADED_BIT]) begin
         divider_ff <= {1'b1, wd[6:0]};
      end
   end

   // Security state loaded at reset; a backdoor unlock forces the unsecured code.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         security_ff <= 8'h00;
      end else begin
         case (state_ff)
            flash_regs_pkg::ST_LOAD: security_ff <= nv_security_i;
            flash_regs_pkg::ST_RUN: begin
               if (unlock_ok_i && key_ok) begin
                  security_ff[1:0] <= flash_regs_pkg::UNSECURED;
               end
            end
            default: security_ff <= security_ff;
         endcase
      end
   end

   // Test mode control: write-all only held in special modes.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_all_ff <= 1'b0;
      end else if (!special_ff) begin
         wr_all_ff <= 1'b0;
      end else if (wr_fire && address_i == flash_regs_pkg::TEST_MODE_CONTROL_OFS) begin
         wr_all_ff <= wd[flash_regs_pkg::WRITE_ALL_BANKS_BIT];
      end
   end

   // Module configuration: unimplemented bits stay zero.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         config_ff <= flash_regs_pkg::MODULE_CONFIGURATION_RST;
      end else if (wr_fire && address_i == flash_regs_pkg::MODULE_CONFIGURATION_OFS) begin
         config_ff <= wd & flash_regs_pkg::MODULE_CONFIGURATION_MASK;
      end
   end

   // Banked protection and violation state, one copy per flash block.
   genvar gi;
   generate
      for (gi = 0; gi < flash_regs_pkg::BANKS; gi = gi + 1) begin : g_bank
         logic sel;
         assign sel = wr_all_ff || (bank == 2'(gi));
         always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               prot_ff[gi] <= flash_regs_pkg::SECTOR_PROTECTION_RST;
            end else if (state_ff == flash_regs_pkg::ST_LOAD) begin
               prot_ff[gi] <= nv_protection_i[8*gi +: 8];
            end else if (wr_fire && sel &&
                         address_i == flash_regs_pkg::SECTOR_PROTECTION_OFS) begin
               prot_ff[gi][7] <= prot_ff[gi][7] && wd[7];
               prot_ff[gi][5] <= prot_ff[gi][5] && wd[5];
               prot_ff[gi][2] <= prot_ff[gi][2] && wd[2];
               if (prot_ff[gi][flash_regs_pkg::HIGH_RANGE_DISABLE_BIT]) begin
                  prot_ff[gi][4:3] <= wd[4:3];
               end
               if (prot_ff[gi][flash_regs_pkg::LOW_RANGE_DISABLE_BIT]) begin
                  prot_ff[gi][1:0] <= wd[1:0];
               end
            end
         end
         always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               viol_ff[gi] <= 1'b0;
            end else if (hit_viol && array_bank_i == 2'(gi)) begin
               viol_ff[gi] <= 1'b1;
            end else if (wr_fire && sel && address_i == flash_regs_pkg::STATUS_REGISTER_OFS &&
                         wd[flash_regs_pkg::PROTECTION_VIOLATION_BIT]) begin
               viol_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Flash timing clock: optional divide by 8, then divide by value plus one.
   assign pre_tick = !divider_ff[flash_regs_pkg::PRESCALE_ENABLE_BIT] ||
                     (pre_cnt_ff == flash_regs_pkg::PRESCALE_LAST);
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_cnt_ff <= 3'h0;
         div_cnt_ff <= 6'h00;
         fclk_tick_ff <= 1'b0;
      end else if (!divider_ff[flash_regs_pkg::DIVIDER_LOADED_BIT]) begin
         pre_cnt_ff <= 3'h0;
         div_cnt_ff <= 6'h00;
         fclk_tick_ff <= 1'b0;
      end else begin
         pre_cnt_ff <= pre_tick ? 3'h0 : pre_cnt_ff + 3'h1;
         fclk_tick_ff <= 1'b0;
         if (pre_tick) begin
            if (div_cnt_ff == divider_ff[5:0]) begin
               div_cnt_ff <= 6'h00;
               fclk_tick_ff <= 1'b1;
            end else begin
               div_cnt_ff <= div_cnt_ff + 6'h01;
            end
         end
      end
   end

   // Interrupt request, array write routing and decoded security outputs.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_ff <= 1'b0;
         launch_ff <= 1'b0;
         key_word_ff <= 1'b0;
         backdoor_ff <= 1'b0;
         secured_ff <= 1'b1;
      end else begin
         irq_ff <= (config_ff[flash_regs_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT] &&
                    |buffer_empty_i) ||
                   (config_ff[flash_regs_pkg::COMPLETE_IRQ_ENABLE_BIT] &&
                    |command_complete_i);
         key_word_ff <= array_write_i && config_ff[flash_regs_pkg::KEY_WRITE_GATE_BIT];
         launch_ff <= array_write_i && !config_ff[flash_regs_pkg::KEY_WRITE_GATE_BIT] &&
                      !hit_viol && (viol_ff == 4'h0);
         backdoor_ff <= key_ok;
         secured_ff <= (security_ff[1:0] != flash_regs_pkg::UNSECURED);
      end
   end

   assign readdata_o = readdata_ff;
   assign waitrequest_o = waitrequest_ff;
   assign launch_o = launch_ff;
   assign key_word_o = key_word_ff;
   assign key_write_gate_o = config_ff[flash_regs_pkg::KEY_WRITE_GATE_BIT];
   assign fclk_tick_o = fclk_tick_ff;
   assign irq_o = irq_ff;
   assign backdoor_enabled_o = backdoor_ff;
   assign secured_o = secured_ff;

   a_div_write_once: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      divider_ff[7] |=> divider_ff[7] && $stable(divider_ff[6:0]))
      else $error("Divider changed after being loaded.");
   a_div_loaded_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (wr_fire && address_i == flash_regs_pkg::CLOCK_DIVIDER_OFS && !divider_ff[7])
      |=> divider_ff[7] && divider_ff[6:0] == $past(writedata_i[6:0]))
      else $error("First divider write not captured.");
   a_prescale_gap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (fclk_tick_ff && divider_ff[6] && $past(divider_ff[7])) |=> !fclk_tick_ff [*7])
      else $error("Prescaled timing tick too early.");
   a_unlock_forced: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_ff == flash_regs_pkg::ST_RUN && unlock_ok_i && key_ok)
      |=> security_ff[1:0] == 2'h2 ##1 !secured_ff)
      else $error("Backdoor unlock did not unsecure.");
   a_backdoor_decode: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      ##1 backdoor_enabled_o == ($past(security_ff[7:6]) == 2'h2))
      else $error("Backdoor enable decode wrong.");
   a_test_mode_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !special_ff |=> !wr_all_ff)
      else $error("Write-all held outside special mode.");
   a_irq_cause: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      irq_o |-> $past((config_ff[7] && |buffer_empty_i) || (config_ff[6] && |command_complete_i)))
      else $error("Interrupt without enabled flag.");
   a_prot_only_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_ff == flash_regs_pkg::ST_RUN && $past(state_ff) == flash_regs_pkg::ST_RUN)
      |-> !$rose(prot_ff[0][7]) && $stable(prot_ff[0][6]))
      else $error("Protection bit returned to open.");
   a_viol_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      hit_viol |=> viol_ff[$past(array_bank_i)] ##1 !launch_o)
      else $error("Violation flag not set.");
endmodule
`default_nettype wire

// >>> verif/cpu_bus_model.sv
// Avalon-MM master standing in for the CPU core on the register bus.
// Assumes the bench raises go_i for one cycle and then waits for done_o.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
   input wire logic ref_clk_i,
   input wire logic go_i,
   input wire logic wr_i,
   input wire logic [11:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic waitrequest_i,
   input wire logic [31:0] readdata_i,
   output logic read_o,
   output logic write_o,
   output logic [11:0] address_o,
   output logic [31:0] writedata_o,
   output logic [3:0] byteenable_o,
   output logic done_o,
   output logic [31:0] rdata_o
);
   initial begin
      read_o = 1'b0;
      write_o = 1'b0;
      address_o = 12'h000;
      writedata_o = 32'h0;
      byteenable_o = 4'h0;
      done_o = 1'b0;
      rdata_o = 32'h0;
   end
   // Holds a request until waitrequest is low, then releases it with scrambled lines.
   always @(posedge ref_clk_i) begin
      done_o <= 1'b0;
      if ((read_o || write_o) && !waitrequest_i) begin
         rdata_o <= readdata_i;
         done_o <= 1'b1;
         read_o <= 1'b0;
         write_o <= 1'b0;
         address_o <= ~address_o;
         writedata_o <= ~writedata_o;
         byteenable_o <= ~byteenable_o;
      end else if (go_i) begin
         read_o <= !wr_i;
         write_o <= wr_i;
         address_o <= addr_i;
         writedata_o <= {24'h0, data_i};
         byteenable_o <= 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> verif/flash_config_protect_regs_bench.sv
// Self-checking bench for the flash configuration and protection register set.
// Assumes the package register map and the bus master model beside it.
`timescale 1ns/10ps
`default_nettype none
module flash_config_protect_regs_bench;
   logic ref_clk_i, reset_n_i, special_mode_i, unlock_ok_i, array_write_i, mass_erase_i;
   logic read_i, write_i, waitrequest_o, launch_o, key_word_o, key_write_gate_o, done, go;
   logic fclk_tick_o, irq_o, backdoor_enabled_o, secured_o, go_wr;
   logic [1:0] array_bank_i;
   logic [3:0] buffer_empty_i, command_complete_i, byteenable_i;
   logic [7:0] nv_security_i, go_data;
   logic [7:0] pv [4];
   logic [11:0] address_i, go_addr;
   logic [15:0] array_addr_i;
   logic [31:0] nv_protection_i, readdata_o, writedata_i, rdv, seed;
   int failures = 0;
   int samples_checked = 0;
   flash_config_protect_regs flash_config_protect_regs_i (.ref_clk_i, .reset_n_i, .address_i,
      .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
      .special_mode_i, .nv_security_i, .nv_protection_i, .unlock_ok_i, .buffer_empty_i,
      .command_complete_i, .array_write_i, .array_bank_i, .array_addr_i, .mass_erase_i,
      .launch_o, .key_word_o, .key_write_gate_o, .fclk_tick_o, .irq_o, .backdoor_enabled_o,
      .secured_o);
   cpu_bus_model cpu_bus_model_i (.ref_clk_i, .go_i(go), .wr_i(go_wr), .addr_i(go_addr),
      .data_i(go_data), .waitrequest_i(waitrequest_o), .readdata_i(readdata_o),
      .read_o(read_i), .write_o(write_i), .address_o(address_i), .writedata_o(writedata_i),
      .byteenable_o(byteenable_i), .done_o(done), .rdata_o(rdv));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic prot_hit(input logic [7:0] p, input logic [15:0] a, input logic m);
      logic [16:0] hs;
      logic [16:0] ls;
      hs = 17'h00800 << p[4:3];
      ls = 17'h00200 << p[1:0];
      if (!p[7]) return 1'b1;
      if (m) return !(p[5] && p[2]);
      return (!p[5] && {1'b0, a} >= 17'h10000 - hs) ||
         (!p[2] && a >= 16'h4000 && {1'b0, a} < 17'h04000 + ls);
   endfunction
   function automatic logic [7:0] prot_next(input logic [7:0] o, input logic [7:0] v);
      logic [7:0] n;
      n = o & {v[7], 1'b1, v[5], 2'h3, v[2], 2'h3};
      if (o[5]) n[4:3] = v[4:3];
      if (o[2]) n[1:0] = v[1:0];
      return n;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk_i);
      go <= 1'b1;
      go_wr <= w;
      go_addr <= a;
      go_data <= d;
      @(posedge ref_clk_i);
      go <= 1'b0;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      chk(32'(done), 32'h1);
   endtask
   task automatic bank(input logic [1:0] b);
      bus(1'b1, flash_regs_pkg::MODULE_CONFIGURATION_OFS, {6'h0, b});
   endtask
   task automatic pulse(input logic [1:0] b, input logic [15:0] a, input logic m);
      @(posedge ref_clk_i);
      array_write_i <= 1'b1;
      array_bank_i <= b;
      array_addr_i <= a;
      mass_erase_i <= m;
      @(posedge ref_clk_i);
      array_write_i <= 1'b0;
      #1;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      logic [31:0] x;
      logic [15:0] a;
      logic [7:0] sv, v;
      logic h;
      int n;
      seed = 32'hbdec;
      {reset_n_i, special_mode_i, unlock_ok_i, array_write_i, mass_erase_i} = 5'h0;
      {go, go_wr, go_addr, go_data, array_bank_i, array_addr_i} = 40'h0;
      {buffer_empty_i, command_complete_i, nv_security_i, nv_protection_i} = 48'h0;
      for (int r = 0; r < 4; r++) begin
         @(posedge ref_clk_i);
         x = rnd();
         sv = {r[1:0], x[5:2], r[1:0] + 2'h1};
         nv_security_i <= sv;
         nv_protection_i <= rnd();
         reset_n_i <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
         reset_n_i <= 1'b1;
         repeat (3) @(posedge ref_clk_i);
         bus(1'b0, flash_regs_pkg::MODULE_CONFIGURATION_OFS, 8'h00);
         chk(rdv, 32'h0);
         bus(1'b0, flash_regs_pkg::CLOCK_DIVIDER_OFS, 8'h00);
         chk(rdv, 32'h0);
         bus(1'b1, flash_regs_pkg::SECURITY_STATE_OFS, ~sv);
         bus(1'b0, flash_regs_pkg::SECURITY_STATE_OFS, 8'h00);
         chk(rdv, {24'h0, sv});
         chk(32'(backdoor_enabled_o), 32'(r == 2));
         chk(32'(secured_o), 32'(r != 1));
         bus(1'b0, 12'h0f0, 8'h00);
         chk(rdv, 32'h0);
         for (int k = 0; k < 4; k++) begin
            pv[k] = nv_protection_i[8*k +: 8];
            bank(k[1:0]);
            bus(1'b0, flash_regs_pkg::SECTOR_PROTECTION_OFS, 8'h00);
            chk(rdv, {24'h0, pv[k]});
         end
         if (r == 2) begin
            @(posedge ref_clk_i);
            unlock_ok_i <= 1'b1;
            @(posedge ref_clk_i);
            unlock_ok_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk(32'(secured_o), 32'h0);
            bus(1'b0, flash_regs_pkg::SECURITY_STATE_OFS, 8'h00);
            chk(rdv, {24'h0, sv[7:2], 2'h2});
         end
         for (int k = 0; k < 12; k++) begin
            x = rnd();
            a = x[17:2];
            if (x[18]) a[15:12] = x[19] ? 4'hf : 4'h4;
            h = prot_hit(pv[x[1:0]], a, x[23:20] == 4'h0);
            pulse(x[1:0], a, x[23:20] == 4'h0);
            chk(32'(launch_o), 32'(!h));
            bank(x[1:0]);
            bus(1'b0, flash_regs_pkg::STATUS_REGISTER_OFS, 8'h00);
            chk(rdv, {24'h0, 2'h0, h, 5'h0});
            if (h) bus(1'b1, flash_regs_pkg::STATUS_REGISTER_OFS, 8'h20);
         end
         $display("test reset load and protection %0d done", r);
      end
      x = rnd();
      v = {x[7], 1'b1, 5'h1f, x[0]};
      bus(1'b1, flash_regs_pkg::CLOCK_DIVIDER_OFS, v);
      bus(1'b1, flash_regs_pkg::CLOCK_DIVIDER_OFS, ~v);
      bus(1'b0, flash_regs_pkg::CLOCK_DIVIDER_OFS, 8'h00);
      chk(rdv, {24'h0, 1'b1, v[6:0]});
      for (n = 0; n < 600 && !fclk_tick_o; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end while (!fclk_tick_o && n < 600);
      chk(32'(n), 32'((v[5:0] + 1) * (v[6] ? 8 : 1)));
      $display("test clock divider done");
      bus(1'b1, flash_regs_pkg::MODULE_CONFIGURATION_OFS, 8'hff);
      bus(1'b0, flash_regs_pkg::MODULE_CONFIGURATION_OFS, 8'h00);
      chk(rdv, 32'he3);
      pulse(2'h0, 16'h8000, 1'b0);
      chk({29'h0, key_write_gate_o, key_word_o, launch_o}, 32'h6);
      for (int i = 0; i < 4; i++) begin
         x = rnd();
         bus(1'b1, flash_regs_pkg::MODULE_CONFIGURATION_OFS, {i[1:0], 6'h0});
         @(posedge ref_clk_i);
         buffer_empty_i <= x[3:0];
         command_complete_i <= x[7:4];
         repeat (3) @(posedge ref_clk_i);
         #1;
         chk(32'(irq_o), 32'((i[1] && x[3:0] != 0) || (i[0] && x[7:4] != 0)));
         bus(1'b0, flash_regs_pkg::STATUS_REGISTER_OFS, 8'h00);
         chk(rdv, {24'h0, x[0], x[4], 6'h0});
      end
      $display("test configuration and interrupts done");
      bus(1'b1, flash_regs_pkg::TEST_MODE_CONTROL_OFS, 8'h10);
      bus(1'b0, flash_regs_pkg::TEST_MODE_CONTROL_OFS, 8'h00);
      chk(rdv, 32'h0);
      @(posedge ref_clk_i);
      special_mode_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      bus(1'b1, flash_regs_pkg::TEST_MODE_CONTROL_OFS, 8'h10);
      bus(1'b0, flash_regs_pkg::TEST_MODE_CONTROL_OFS, 8'h00);
      chk(rdv, 32'h10);
      for (int i = 0; i < 6; i++) begin
         x = rnd();
         if (i == 3) bus(1'b1, flash_regs_pkg::TEST_MODE_CONTROL_OFS, 8'h00);
         bank(x[1:0]);
         bus(1'b1, flash_regs_pkg::SECTOR_PROTECTION_OFS, x[15:8]);
         for (int k = 0; k < 4; k++) begin
            if (i < 3 || k == x[1:0]) pv[k] = prot_next(pv[k], x[15:8]);
            bank(k[1:0]);
            bus(1'b0, flash_regs_pkg::SECTOR_PROTECTION_OFS, 8'h00);
            chk(rdv, {24'h0, pv[k]});
         end
      end
      $display("test protection writes done");
      conclude();
   end
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      failures++;
      $display("watchdog expired");
      conclude();
   end
endmodule
`default_nettype wire
